// ===== rtl/ckpg_consts.svh
// Constants for the clock output power gating block
`ifndef CKPG_CONSTS_SVH
`define CKPG_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CKPG_CTRL_OFF 8'h00
`define CKPG_STAT_OFF 8'h04
`define CKPG_CTRL_RST 8'h0f
`define CKPG_WAKE_BIT 5
`define CKPG_STAT_LOCK_BIT 4
`define CKPG_STAT_STRAP_BIT 5
`define CKPG_STAT_PG_BIT 6
`define CKPG_STAT_LATE_BIT 7
`define CKPG_STAT_SS_LSB 8
`define CKPG_STAT_ADDR_LSB 10
`define CKPG_RESP_OK 2'h0
`define CKPG_RESP_ERR 2'h2

// ----------------------------------------------------------------
// Straps and timing
// ----------------------------------------------------------------
`define CKPG_ADDR_STRAP0 7'h68
`define CKPG_ADDR_STRAP1 7'h6a
`define CKPG_TRI_HIGH 2'h2
`define CKPG_TRI_MID 2'h1
`define CKPG_CLK_MHZ 20
`define CKPG_TDRV_US 300

`endif

// ===== rtl/ckpg_pkg.sv
// Types for the clock output power gating block
package ckpg_pkg;
    typedef enum logic [1:0] {CKPG_OFF, CKPG_WAIT_LOCK, CKPG_RUN}
        ckpg_state_type;
    typedef enum logic [1:0] {CKPG_SS_OFF, CKPG_SS_025, CKPG_SS_050}
        ckpg_spread_type;
endpackage

// ===== rtl/ckpg_gate_if.sv
// Run requests and gated pair outputs between control and gate
`timescale 1ns/1ps
interface ckpg_gate_if #(parameter int NPAIR = 4);
    logic [NPAIR-1:0] run_req;
    logic [NPAIR-1:0] dif_true;
    logic [NPAIR-1:0] dif_comp;
    logic [NPAIR-1:0] running;
    modport ctl (output run_req, input dif_true, input dif_comp,
        input running);
    modport gate (input run_req, output dif_true, output dif_comp,
        output running);
endinterface

// ===== rtl/ckpg_pair_gate.sv
// Glitch-free per-pair gating of the differential output clock
`timescale 1ns/1ps
module ckpg_pair_gate
    import ckpg_pkg::*;
#(
    parameter int NPAIR = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    ckpg_gate_if.gate gif
);
    logic phase_ff;
    logic [NPAIR-1:0] en_ff;
    logic [NPAIR-1:0] true_ff;
    logic [NPAIR-1:0] comp_ff;

    // ------------------------------------------------------------
    // Output clock phase, half the system clock
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    assign gif.dif_true = true_ff;
    assign gif.dif_comp = comp_ff;
    assign gif.running = en_ff;

    // ------------------------------------------------------------
    // Per pair gate
    // ------------------------------------------------------------
    for (genvar i = 0; i < NPAIR; i++) begin : g_pair
        logic nxt_en;
        // Enable moves only while the true leg is about to go low
        assign nxt_en = phase_ff ? gif.run_req[i] : en_ff[i]; // R12

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                en_ff[i] <= 1'b0;
                true_ff[i] <= 1'b0;
                comp_ff[i] <= 1'b0;
            end else begin
                en_ff[i] <= nxt_en; // R10
                true_ff[i] <= nxt_en & ~phase_ff; // R5
                comp_ff[i] <= nxt_en & phase_ff; // R5
            end
        end

        en_start_a: assert property (@(posedge sys_clk) disable iff (rst)
            $rose(gif.run_req[i]) ##1 gif.run_req[i]
            |-> ##[0:1] en_ff[i]) // R10
            else $error("pair did not start in time");
        en_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
            $fell(gif.run_req[i]) ##1 !gif.run_req[i]
            |-> ##[0:1] !en_ff[i]) // R10
            else $error("pair did not stop in time");
        whole_pulse_a: assert property (@(posedge sys_clk)
            disable iff (rst)
            $changed(en_ff[i]) |-> !phase_ff && !true_ff[i]) // R12
            else $error("pair gated mid pulse");
        legs_off_a: assert property (@(posedge sys_clk) disable iff (rst)
            !en_ff[i] |=> !true_ff[i] || $past(en_ff[i])) // R5
            else $error("disabled pair toggled");
        legs_diff_a: assert property (@(posedge sys_clk) disable iff (rst)
            !(true_ff[i] && comp_ff[i])) // R5
            else $error("both legs high");
    end
endmodule

// ===== rtl/ckpg_top.sv
// Clock output power gating control with AXI4-Lite registers
// Behaviour
// R1: Bus address is 1101000 for strap 0, 1101010 for strap 1.
// R2: First power-good high latches all straps and starts up.
// R3: Power-good low forces both legs of every pair low.
// R4: Reference floats until first power-good, then power-down drives it low.
// R5: Pair runs only with power-good, bus bit set and pin low.
// R6: Spread strap high gives -0.5%, mid -0.25%, low off.
// R7: No differential clock toggles until the PLL reports lock.
// R8: Wake bit keeps reference running in power-down; otherwise all stop.
// R9: Address strap pin is input until latched, then reference copy.
// R10: Pair starts and stops one to three output clocks after pin.
// R11: Differential outputs enabled within 300 us after power-down release.
// R12: Pair enable changes aligned to output clock, no truncated pulses.
`timescale 1ns/1ps
`include "ckpg_consts.svh"
module ckpg_top
    import ckpg_pkg::*;
#(
    parameter int NPAIR = 4,
    parameter int TDRV_CYC = `CKPG_TDRV_US * `CKPG_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_good_powerdown_n,
    input wire logic pll_locked,
    input wire logic crystal_in,
    input wire logic [NPAIR-1:0] pair_output_enable_n,
    input wire logic [1:0] spread_strap_lvl,
    input wire logic bus_addr_strap_i,
    output logic bus_addr_strap_o,
    output logic bus_addr_strap_oe,
    output logic [NPAIR-1:0] diff_clock_pair_true,
    output logic [NPAIR-1:0] diff_clock_pair_comp,
    output logic [6:0] bus_addr,
    output ckpg_spread_type spread_sel
);
    localparam int SW = NPAIR + 6;

    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic pg_s, lock_s, xtal_s, strap_s;
    logic [NPAIR-1:0] oe_n_s;
    logic [1:0] ss_s;
    logic strap_done_ff;
    logic [6:0] bus_addr_ff;
    ckpg_spread_type spread_ff;
    ckpg_spread_type nxt_spread;
    ckpg_state_type state_ff;
    ckpg_state_type nxt_state;
    logic [15:0] drv_cnt_ff;
    logic late_ff;
    logic ref_o_ff;
    logic [7:0] ctrl_ff;
    logic wake;
    logic wr_go, rd_go;
    logic bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [31:0] status;

    ckpg_gate_if #(.NPAIR(NPAIR)) gif ();

    ckpg_pair_gate #(.NPAIR(NPAIR)) u_gate (
        .sys_clk(sys_clk),
        .rst(rst),
        .gif(gif.gate)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {power_good_powerdown_n, pll_locked, crystal_in,
                bus_addr_strap_i, spread_strap_lvl, pair_output_enable_n};
            sync2_ff <= sync1_ff;
        end
    end

    assign {pg_s, lock_s, xtal_s, strap_s, ss_s, oe_n_s} = sync2_ff;

    // ------------------------------------------------------------
    // Strap latch on first power-good
    // ------------------------------------------------------------
    always_comb begin
        if (ss_s == `CKPG_TRI_HIGH) begin
            nxt_spread = CKPG_SS_050; // R6
        end else if (ss_s == `CKPG_TRI_MID) begin
            nxt_spread = CKPG_SS_025; // R6
        end else begin
            nxt_spread = CKPG_SS_OFF; // R6
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_done_ff <= 1'b0;
            bus_addr_ff <= `CKPG_ADDR_STRAP0;
            spread_ff <= CKPG_SS_OFF;
        end else if (pg_s && !strap_done_ff) begin
            strap_done_ff <= 1'b1; // R2
            bus_addr_ff <= strap_s ? `CKPG_ADDR_STRAP1
                : `CKPG_ADDR_STRAP0; // R1
            spread_ff <= nxt_spread; // R6
        end
    end

    assign bus_addr = bus_addr_ff;
    assign spread_sel = spread_ff;

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    always_comb begin
        case (state_ff)
            CKPG_OFF: nxt_state = pg_s ? CKPG_WAIT_LOCK : CKPG_OFF; // R11
            CKPG_WAIT_LOCK: nxt_state = lock_s ? CKPG_RUN
                : CKPG_WAIT_LOCK; // R7
            CKPG_RUN: nxt_state = lock_s ? CKPG_RUN : CKPG_WAIT_LOCK;
            default: nxt_state = CKPG_OFF;
        endcase
        if (!pg_s) begin
            nxt_state = CKPG_OFF; // R3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= CKPG_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Flags a PLL that misses the enable deadline
    always_ff @(posedge sys_clk) begin
        if (rst || state_ff != CKPG_WAIT_LOCK) begin
            drv_cnt_ff <= '0;
        end else if (drv_cnt_ff != 16'(TDRV_CYC)) begin
            drv_cnt_ff <= drv_cnt_ff + 16'h0001; // R11
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || state_ff == CKPG_OFF) begin
            late_ff <= 1'b0;
        end else if (drv_cnt_ff == 16'(TDRV_CYC)) begin
            late_ff <= 1'b1; // R11
        end
    end

    // ------------------------------------------------------------
    // Pair requests and reference output
    // ------------------------------------------------------------
    assign wake = ctrl_ff[`CKPG_WAKE_BIT];
    assign gif.run_req = (state_ff == CKPG_RUN)
        ? (ctrl_ff[NPAIR-1:0] & ~oe_n_s) : '0; // R5
    assign diff_clock_pair_true = gif.dif_true;
    assign diff_clock_pair_comp = gif.dif_comp;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_o_ff <= 1'b0;
        end else begin
            ref_o_ff <= strap_done_ff && (pg_s || wake) && xtal_s; // R8
        end
    end

    assign bus_addr_strap_oe = strap_done_ff; // R9
    assign bus_addr_strap_o = ref_o_ff; // R4

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    assign rd_go = s_axi_arvalid && !rvalid_ff;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    always_comb begin
        status = '0;
        status[NPAIR-1:0] = gif.running;
        status[`CKPG_STAT_LOCK_BIT] = lock_s;
        status[`CKPG_STAT_STRAP_BIT] = strap_done_ff;
        status[`CKPG_STAT_PG_BIT] = pg_s;
        status[`CKPG_STAT_LATE_BIT] = late_ff;
        status[`CKPG_STAT_SS_LSB +: 2] = spread_ff;
        status[`CKPG_STAT_ADDR_LSB +: 7] = bus_addr_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= `CKPG_CTRL_RST;
        end else if (wr_go && s_axi_awaddr == `CKPG_CTRL_OFF
                && s_axi_wstrb[0]) begin
            ctrl_ff <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `CKPG_RESP_OK;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (s_axi_awaddr == `CKPG_CTRL_OFF
                || s_axi_awaddr == `CKPG_STAT_OFF)
                ? `CKPG_RESP_OK : `CKPG_RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `CKPG_RESP_OK;
            rdata_ff <= '0;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `CKPG_RESP_OK;
            if (s_axi_araddr == `CKPG_CTRL_OFF) begin
                rdata_ff <= {24'h000000, ctrl_ff};
            end else if (s_axi_araddr == `CKPG_STAT_OFF) begin
                rdata_ff <= status;
            end else begin
                rdata_ff <= '0;
                rresp_ff <= `CKPG_RESP_ERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    addr_select_a: assert property ($rose(strap_done_ff) |-> bus_addr ==
        ($past(strap_s) ? `CKPG_ADDR_STRAP1 : `CKPG_ADDR_STRAP0)) // R1
        else $error("wrong bus address latched");
    strap_hold_a: assert property (strap_done_ff |=> strap_done_ff
        && $stable(bus_addr) && $stable(spread_sel)) // R2
        else $error("strap latch changed");
    pd_outputs_a: assert property (!pg_s [*5] |->
        diff_clock_pair_true == '0 && diff_clock_pair_comp == '0) // R3
        else $error("pair active in power-down");
    ref_pd_low_a: assert property ((strap_done_ff && !pg_s && !wake) [*2]
        |-> bus_addr_strap_oe && !bus_addr_strap_o) // R4
        else $error("reference not low in power-down");
    spread_map_a: assert property ($rose(strap_done_ff) |-> spread_sel ==
        ($past(ss_s) == `CKPG_TRI_HIGH ? CKPG_SS_050 :
        $past(ss_s) == `CKPG_TRI_MID ? CKPG_SS_025 : CKPG_SS_OFF)) // R6
        else $error("wrong spread latched");
    lock_block_a: assert property (!lock_s [*5] |->
        diff_clock_pair_true == '0 && diff_clock_pair_comp == '0) // R7
        else $error("pair toggles without lock");
    wake_ref_a: assert property (strap_done_ff && !pg_s && wake
        |=> bus_addr_strap_o == $past(xtal_s)) // R8
        else $error("reference stopped with wake set");
    strap_input_a: assert property (!strap_done_ff |->
        !bus_addr_strap_oe && !bus_addr_strap_o) // R9
        else $error("strap pin driven before latch");
    enable_time_a: assert property ((pg_s && lock_s) [*3] |->
        state_ff == CKPG_RUN) // R11
        else $error("outputs not enabled after release");

    run_cov: cover property (state_ff == CKPG_RUN && gif.running != '0);
    wake_cov: cover property (!pg_s && wake && bus_addr_strap_o);
    strap_cov: cover property ($rose(strap_done_ff) && strap_s);
endmodule

// ===== bench/ckpg_board_model.sv
// Board model: crystal, PLL lock and strap pin at its resistor level
`timescale 1ns/1ps
module ckpg_board_model #(
    parameter int LOCK_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic pg,
    input wire logic lock_en,
    input wire logic strap_lvl,
    input wire logic strap_o,
    input wire logic strap_oe,
    output logic crystal_in,
    output logic pll_locked,
    output logic strap_pin
);
    int lock_cnt = 0;
    // 25 MHz reference, phase unrelated to the system clock
    initial begin
        crystal_in = 1'b0;
        #7;
        forever #20 crystal_in = ~crystal_in;
    end
    always_ff @(posedge sys_clk) begin
        lock_cnt <= (pg && lock_en) ? lock_cnt + 1 : 0;
    end
    assign pll_locked = lock_cnt > LOCK_CYC;
    // Pin shows the strap resistor unless the device drives it
    assign strap_pin = strap_oe ? strap_o : strap_lvl;
endmodule

// ===== bench/clock_output_power_gating_tb.sv
// Self-checking bench for the clock output power gating block
`timescale 1ns/1ps
`include "ckpg_consts.svh"
module clock_output_power_gating_tb import ckpg_pkg::*;;
    logic sys_clk = 0, rst = 1, pg = 0, lock_en = 1, strap_lvl = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] oe_n = 4'hf;
    logic [1:0] ss_lvl = 0;
    logic awready, wready, bvalid, arready, rvalid, crystal, locked;
    logic strap_o, strap_oe, strap_pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] dtrue, dcomp;
    logic [6:0] baddr;
    ckpg_spread_type ss_sel;
    int fail_count = 0, n_tests = 0, seed = 32'he8bb;

    always #25 sys_clk = ~sys_clk;

    ckpg_top #(.NPAIR(4), .TDRV_CYC(20)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .power_good_powerdown_n(pg),
        .pll_locked(locked), .crystal_in(crystal),
        .pair_output_enable_n(oe_n), .spread_strap_lvl(ss_lvl),
        .bus_addr_strap_i(strap_pin), .bus_addr_strap_o(strap_o),
        .bus_addr_strap_oe(strap_oe), .diff_clock_pair_true(dtrue),
        .diff_clock_pair_comp(dcomp), .bus_addr(baddr), .spread_sel(ss_sel));

    ckpg_board_model board_u (
        .sys_clk(sys_clk), .pg(pg), .lock_en(lock_en),
        .strap_lvl(strap_lvl), .strap_o(strap_o), .strap_oe(strap_oe),
        .crystal_in(crystal), .pll_locked(locked), .strap_pin(strap_pin));

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask

    function automatic ckpg_spread_type exp_ss(logic [1:0] lvl);
        if (lvl == `CKPG_TRI_HIGH) return CKPG_SS_050;
        if (lvl == `CKPG_TRI_MID) return CKPG_SS_025;
        return CKPG_SS_OFF;
    endfunction

    task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do @(posedge sys_clk); while (!(awready && wready));
        awvalid <= 0;
        wvalid <= 0;
        bready <= 1;
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        bready <= 0;
        chk("bresp", er, bresp);
    endtask

    task automatic axi_rd(logic [7:0] a, logic [31:0] m, logic [31:0] e,
                          logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 0;
        rready <= 1;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rready <= 0;
        chk("rdata", e & m, rdata & m);
        chk("rresp", er, rresp);
    endtask

    // Which pairs show a true-leg pulse over n cycles
    task automatic act(int n, output logic [3:0] run);
        run = 0;
        repeat (n) begin
            @(posedge sys_clk);
            run |= dtrue;
        end
    endtask

    task automatic ref_act(int n, output logic seen);
        logic last;
        last = strap_o;
        seen = 0;
        repeat (n) begin
            @(posedge sys_clk);
            seen |= strap_o !== last;
            last = strap_o;
        end
    endtask

    task automatic power_up(logic sa, logic [1:0] lvl);
        rst <= 1;
        pg <= 0;
        strap_lvl <= sa;
        ss_lvl <= lvl;
        cyc(10);
        rst <= 0;
        cyc(4);
        chk("ref released", 0, strap_oe);
        pg <= 1;
        cyc(6);
        strap_lvl <= ~sa;
        ss_lvl <= 2'h3;
        cyc(4);
    endtask

    always @(negedge sys_clk) begin
        if ((dtrue & dcomp) !== 4'h0) begin
            chk("legs overlap", 0, dtrue & dcomp);
        end
    end

    initial begin
        cyc(20000);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        logic [3:0] run;
        logic [7:0] ctl;
        logic seen;
        int t;
        for (int i = 0; i < 3; i++) begin
            power_up(i[0], 2'(2 - i));
            chk("bus addr", i[0] ? 7'b1101010 : 7'b1101000, baddr);
            chk("spread", exp_ss(2'(2 - i)), ss_sel);
            chk("strap drive", 1, strap_oe);
            ref_act(20, seen);
            chk("ref copy", 1, seen);
        end
        lock_en <= 0;
        power_up(0, 0);
        oe_n <= 4'h0;
        act(40, run);
        chk("pairs before lock", 0, run);
        lock_en <= 1;
        act(30, run);
        chk("pairs after lock", 4'hf, run);
        axi_rd(`CKPG_CTRL_OFF, 32'hff, `CKPG_CTRL_RST, `CKPG_RESP_OK);
        axi_rd(8'h08, 32'hffffffff, 0, `CKPG_RESP_ERR);
        axi_wr(8'h10, 0, `CKPG_RESP_ERR);
        axi_wr(`CKPG_STAT_OFF, 0, `CKPG_RESP_OK);
        // Pairs, lock, latched, power good and late flag all set
        axi_rd(`CKPG_STAT_OFF, 32'h1ffff, (32'h68 << 10) | 32'hff,
               `CKPG_RESP_OK);
        repeat (12) begin
            ctl = 8'($random(seed));
            oe_n <= 4'($random(seed));
            axi_wr(`CKPG_CTRL_OFF, {28'h0, ctl[3:0]}, `CKPG_RESP_OK);
            cyc(8);
            act(12, run);
            chk("pair run", ctl[3:0] & ~oe_n, run);
        end
        axi_wr(`CKPG_CTRL_OFF, 32'h0f, `CKPG_RESP_OK);
        oe_n <= 4'hf;
        cyc(10);
        oe_n <= 4'h0;
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (dtrue[0] !== 1'b1 && t < 20);
        chk("start latency", 1, t >= 2 && t <= 7);
        oe_n <= 4'hf;
        cyc(7);
        act(10, run);
        chk("stop latency", 0, run);
        oe_n <= 4'h0;
        pg <= 0;
        cyc(8);
        act(10, run);
        chk("pd pairs", 0, run | dcomp);
        ref_act(20, seen);
        chk("pd ref still", 0, seen);
        chk("pd ref low", 2'b10, {strap_oe, strap_o});
        axi_wr(`CKPG_CTRL_OFF, 32'h2f, `CKPG_RESP_OK);
        cyc(6);
        ref_act(20, seen);
        chk("wake ref", 1, seen);
        act(10, run);
        chk("wake pairs", 0, run);
        pg <= 1;
        act(28, run);
        chk("pd exit", 4'hf, run);
        tally_and_finish();
    end
endmodule
